// File: bench/osc_ctrl_bench.sv
`include "osc_map.vh"
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
  num_errors++; $display("ERROR %s exp %h seen %h", n, x, g); end end
module osc_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, reset_divider_config = 4'h2;
  logic [3:0] divider_current, dv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, switch_permit_config = 1;
  logic multiplier_lock_in = 0, periph_ext_req = 1, p, h;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, secondary_power_select, periph_ext_use_multiplier;
  logic multiplier_run, switch_event;
  logic [2:0] reset_source_config = 3'h6, fast_freq_select;
  logic [2:0] source_current, s, cs, fq;
  logic [7:0] source_ready_in = 0, f;
  logic [6:0] osc_usable_in = 0, osc_periph_req = 0, osc_run, pr, u;
  logic [5:0] auto_trim_value = 0, trim_value, t, a;
  int num_errors = 0, samples_checked = 0, cyc = 0, evts = 0, k, n, w;
  osc_ctrl dut (.*);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (switch_event === 1'b1) evts++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  // ****************************************
  // verdict task, expected-value functions and bus tasks
  // ****************************************
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic exp_pll(input logic en, lk, ext);
    return en & lk & ext;
  endfunction
  function automatic logic [6:0] exp_run(input logic [7:0] fe,
                                         input logic [6:0] rq);
    return {fe[7:2] | rq[6:1], rq[0]};
  endfunction
  task automatic wr(input [11:0] i, input [7:0] d);
    bit aw, wd;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && wd)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) aw = 1;
      if (s_axi_wready === 1'b1) wd = 1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !wd;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input [11:0] i);
    @(posedge clk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic ck(input [11:0] i, input [7:0] x);
    rdr(i);
    `CHK("register", {24'h0, x}, rd)
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(91));
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    repeat (2) @(posedge clk);
    ck(`OSC_IDX_REQ, 8'h62);
    ck(`OSC_IDX_CUR, 8'h62);
    ck(`OSC_IDX_SWCTL, 8'h10);
    ck(`OSC_IDX_STAT, 8'h00);
    ck(`OSC_IDX_FORCE, 8'h00);
    ck(`OSC_IDX_TRIM, 8'h00);
    ck(`OSC_IDX_FRQ, 8'h00);
    for (k = 3; k < 8; k += 4) begin
      wr(`OSC_IDX_REQ, {1'b0, 3'(k), 4'h5});
      ck(`OSC_IDX_REQ, 8'h62);
    end
    cs = 3'h6;
    for (n = 0; n < 4; n++) begin
      do s = 3'($urandom); while (s == 3 || s == 7 || s == cs);
      dv = 4'($urandom);
      p = 1'($urandom);
      h = n[0];
      source_ready_in <= 0;
      wr(`OSC_IDX_SWCTL, {h, p, 6'h0});
      wr(`OSC_IDX_REQ, {1'b0, s, dv});
      ck(`OSC_IDX_REQ, {1'b0, s, dv});
      ck(`OSC_IDX_SWCTL, {h, p, 6'h0});
      `CHK("power", p, secondary_power_select)
      source_ready_in[s] <= 1;
      // margin covers the three-stage ready synchroniser
      repeat (10) @(posedge clk);
      if (h) begin
        ck(`OSC_IDX_SWCTL, {h, p, 6'h08});
        `CHK("source", cs, source_current)
        wr(`OSC_IDX_SWCTL, {1'b0, p, 6'h0});
      end
      for (w = 0; w < 20 && evts == n; w++) @(posedge clk);
      cs = s;
      ck(`OSC_IDX_CUR, {1'b0, s, dv});
      ck(`OSC_IDX_SWCTL, {1'b0, p, 6'h10});
      `CHK("divider", dv, divider_current)
      `CHK("events", n + 1, evts)
    end
    for (k = 0; k < 8; k++) begin
      wr(`OSC_IDX_FRQ, 8'(k));
      if (k <= `OSC_FRQ_MAX) fq = 3'(k);
      ck(`OSC_IDX_FRQ, {5'h0, fq});
      `CHK("freq", fq, fast_freq_select)
    end
    t = 6'($urandom);
    a = 6'($urandom);
    wr(`OSC_IDX_TRIM, {2'h0, t});
    ck(`OSC_IDX_TRIM, {2'h0, t});
    `CHK("trim", t, trim_value)
    auto_trim_value <= a;
    wr(`OSC_IDX_AUTO, 8'h80);
    wr(`OSC_IDX_TRIM, {2'h0, ~t});
    ck(`OSC_IDX_TRIM, {2'h0, a});
    `CHK("trim", a, trim_value)
    wr(`OSC_IDX_AUTO, 8'h00);
    for (n = 0; n < 3; n++) begin
      f = 8'($urandom);
      pr = 7'($urandom);
      u = 7'($urandom);
      osc_periph_req <= pr;
      osc_usable_in <= u;
      multiplier_lock_in <= n[0];
      wr(`OSC_IDX_FORCE, f);
      repeat (6) @(posedge clk);
      ck(`OSC_IDX_FORCE, f & `OSC_FEN_MASK);
      `CHK("run", exp_run(f, pr), osc_run)
      `CHK("mult", f[0], periph_ext_use_multiplier)
      rdr(`OSC_IDX_STAT);
      `CHK("ready", u, rd[7:1])
      `CHK("pll", exp_pll(f[0], n[0], u[6]), rd[0])
    end
    osc_periph_req <= 0;
    rdr(12'h100);
    `CHK("resp", `OSC_RESP_SLVERR, rr)
    `CHK("data", 32'h0, rd)
    switch_permit_config <= 0;
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    repeat (2) @(posedge clk);
    wr(`OSC_IDX_REQ, 8'h15);
    ck(`OSC_IDX_REQ, 8'h62);
    give_verdict;
  end
endmodule // osc_ctrl_bench

// File: bench/osc_ctrl_props.sv
module osc_ctrl_props (
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // bus handshakes
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  // oscillator side
  input wire [6:0] osc_periph_req,
  input wire [6:0] osc_run,
  input wire [2:0] source_current,
  input wire [3:0] divider_current,
  input wire       switch_event
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_run_req;
    (osc_run & $past(osc_periph_req)) == $past(osc_periph_req)
      && osc_run[0] == $past(osc_periph_req[0]);
  endproperty
  a_run_req: assert property (p_run_req)
    else $error("oscillator run misses a request");
  property p_evt_chg;
    switch_event |-> !$stable({source_current, divider_current});
  endproperty
  a_evt_chg: assert property (p_evt_chg)
    else $error("switch pulse without new selection");
  // straps load once after reset without a pulse
  property p_cur_hold;
    !$stable({source_current, divider_current}) && !$past(sys_rst, 2)
      |-> switch_event;
  endproperty
  a_cur_hold: assert property (p_cur_hold)
    else $error("selection changed without switch");
  property p_evt_pulse;
    switch_event |=> !switch_event;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("switch pulse too long");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("read answer late");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write answer late");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("read ready held");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse)
    else $error("write ready held");
  c_evt: cover property (switch_event);
  c_bv: cover property (s_axi_bvalid);
  c_rv: cover property (s_axi_rvalid);
endmodule // osc_ctrl_props

bind osc_ctrl osc_ctrl_props u_props (.clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .osc_periph_req,
  .osc_run, .source_current, .divider_current, .switch_event);

// File: design/osc_ctrl.v
`include "osc_map.vh"

module osc_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // axi4-lite write address
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // configuration straps
  input  wire        switch_permit_config,
  input  wire [2:0]  reset_source_config,
  input  wire [3:0]  reset_divider_config,
  // per-source ready, indexed by source code, from the oscillators
  input  wire [7:0]  source_ready_in,
  // oscillator status: ext, fast, med, slow, sec, adc rc, special
  input  wire [6:0]  osc_usable_in,
  input  wire        multiplier_lock_in,
  // peripheral demand for each oscillator, same order
  input  wire [6:0]  osc_periph_req,
  input  wire        periph_ext_req,
  // auto trim engine
  input  wire [5:0]  auto_trim_value,
  // oscillator controls
  output reg  [6:0]  osc_run,
  output reg         secondary_power_select,
  output reg  [2:0]  fast_freq_select,
  output reg  [5:0]  trim_value,
  output reg         periph_ext_use_multiplier,
  output reg         multiplier_run,
  // system clock selection
  output reg  [2:0]  source_current,
  output reg  [3:0]  divider_current,
  output reg         switch_event
);

  // ****************************************************************
  // ** straps and pin synchronisers
  // ****************************************************************
  reg        strap_done_r;
  reg        permit_r;
  reg [2:0]  source_request_r;
  reg [3:0]  divider_request_r;
  wire [7:0] rdy_r;
  wire [6:0] usable_r;
  wire       lock_r;

  // pins change only once two later stages agree
  osc_sync #(
    .W(8)
  ) u_rdy_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (source_ready_in),
    .q       (rdy_r)
  );

  osc_sync #(
    .W(7)
  ) u_usable_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (osc_usable_in),
    .q       (usable_r)
  );

  osc_sync #(
    .W(1)
  ) u_lock_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (multiplier_lock_in),
    .q       (lock_r)
  );

  // ****************************************************************
  // ** register state
  // ****************************************************************
  reg        hold_r;
  reg        spwr_r;
  reg [7:0]  force_r;
  reg [5:0]  trim_r;
  reg [2:0]  frq_r;
  reg        auto_r;
  reg        nrdy_r;

  wire       switching = (source_request_r != source_current) ||
                         (divider_request_r != divider_current);
  wire       req_ready = rdy_r[source_request_r];

  // ****************************************************************
  // ** axi4-lite slave
  // ****************************************************************
  reg        aw_have_r, w_have_r;
  reg [11:0] aw_idx_r;
  reg [7:0]  wd_r;
  reg        wb0_r;

  wire       do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  wire       wr_hit   = do_write && wb0_r;
  wire [2:0] wsrc     = wd_r[`OSC_SRC_HI:`OSC_SRC_LO];
  wire       wsrc_ok  = (wsrc != `OSC_SRC_RSVD_A) &&
                        (wsrc != `OSC_SRC_RSVD_B);

  function idx_ok;
    input [11:0] i;
    begin
      idx_ok = (i >= `OSC_IDX_REQ) && (i <= `OSC_IDX_AUTO);
    end
  endfunction

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OSC_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= 12'h000;
      wd_r          <= 8'h00;
      wb0_r         <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wd_r     <= s_axi_wdata[7:0];
        wb0_r    <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_ok(aw_idx_r) ? `OSC_RESP_OKAY
                                         : `OSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [7:0] rd_nxt;
  always @* begin
    rd_nxt = 8'h00;
    case (s_axi_araddr[13:2])
      `OSC_IDX_REQ:   rd_nxt = {1'b0, source_request_r,
                                divider_request_r};
      `OSC_IDX_CUR:   rd_nxt = {1'b0, source_current,
                                divider_current};
      `OSC_IDX_SWCTL: rd_nxt = {hold_r, spwr_r, 1'b0, !switching,
                                nrdy_r, 3'h0};
      `OSC_IDX_STAT:  rd_nxt = {usable_r,
                                multiplier_run & usable_r[6] &
                                lock_r};
      `OSC_IDX_FORCE: rd_nxt = force_r;
      `OSC_IDX_TRIM:  rd_nxt = {2'h0, trim_r};
      `OSC_IDX_FRQ:   rd_nxt = {5'h00, frq_r};
      `OSC_IDX_AUTO:  rd_nxt = {auto_r, 7'h00};
      default:        rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_nxt};
        s_axi_rresp  <= idx_ok(s_axi_araddr[13:2]) ? `OSC_RESP_OKAY
                                                   : `OSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // ** software registers
  // ****************************************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_r      <= 1'b0;
      permit_r          <= 1'b0;
      source_request_r  <= 3'h0;
      divider_request_r <= 4'h0;
      hold_r            <= 1'b0;
      spwr_r            <= 1'b0;
      force_r           <= `OSC_RST_ZERO;
      trim_r            <= 6'h00;
      frq_r             <= `OSC_RST_FRQ;
      auto_r            <= 1'b0;
    end else begin
      // straps caught once after release
      if (!strap_done_r) begin
        strap_done_r      <= 1'b1;
        permit_r          <= switch_permit_config;
        source_request_r  <= reset_source_config;
        divider_request_r <= reset_divider_config;
      end else if (wr_hit && aw_idx_r == `OSC_IDX_REQ &&
                   permit_r && wsrc_ok) begin
        source_request_r  <= wsrc;
        divider_request_r <= wd_r[`OSC_DIV_HI:`OSC_DIV_LO];
      end
      if (wr_hit && aw_idx_r == `OSC_IDX_SWCTL) begin
        hold_r <= wd_r[`OSC_HOLD_BIT];
        spwr_r <= wd_r[`OSC_SPWR_BIT];
      end
      if (wr_hit && aw_idx_r == `OSC_IDX_FORCE) begin
        force_r <= wd_r & `OSC_FEN_MASK;
      end
      // reserved frequency codes are not stored
      if (wr_hit && aw_idx_r == `OSC_IDX_FRQ &&
          wd_r[2:0] <= `OSC_FRQ_MAX) begin
        frq_r <= wd_r[2:0];
      end
      if (wr_hit && aw_idx_r == `OSC_IDX_AUTO) begin
        auto_r <= wd_r[`OSC_AUTO_BIT];
      end
      if (auto_r) begin
        trim_r <= auto_trim_value;
      end else if (wr_hit && aw_idx_r == `OSC_IDX_TRIM) begin
        trim_r <= wd_r[5:0];
      end
    end
  end

  // ****************************************************************
  // ** clock switch
  // ****************************************************************
  // one stage of ready before the switch mirrors the status timing
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nrdy_r          <= 1'b0;
      source_current  <= 3'h0;
      divider_current <= 4'h0;
      switch_event    <= 1'b0;
    end else begin
      switch_event <= 1'b0;
      if (!strap_done_r) begin
        source_current  <= reset_source_config;
        divider_current <= reset_divider_config;
        nrdy_r          <= 1'b0;
      end else if (switching && req_ready) begin
        nrdy_r <= 1'b1;
        if (nrdy_r && !hold_r) begin
          source_current  <= source_request_r;
          divider_current <= divider_request_r;
          nrdy_r          <= 1'b0;
          switch_event    <= 1'b1;
        end
      end else begin
        nrdy_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // ** oscillator enables
  // ****************************************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run                   <= 7'h00;
      secondary_power_select    <= 1'b0;
      fast_freq_select          <= `OSC_RST_FRQ;
      trim_value                <= 6'h00;
      periph_ext_use_multiplier <= 1'b0;
      multiplier_run            <= 1'b0;
    end else begin
      // force bits 7..2 map to ext..adc rc; special osc on demand only
      osc_run <= {force_r[7:2], 1'b0} | osc_periph_req;
      secondary_power_select    <= spwr_r;
      fast_freq_select          <= frq_r;
      trim_value                <= trim_r;
      // affects peripherals only, never source_current
      periph_ext_use_multiplier <= force_r[`OSC_PLLSEL_BIT];
      multiplier_run <= force_r[`OSC_PLLSEL_BIT] &
                        periph_ext_req;
    end
  end

endmodule // osc_ctrl

// ****************************************************************
// ** three-stage pin synchroniser
// ****************************************************************
// a bit moves only when stages two and three agree, so a
// metastable first stage never reaches the logic; costs one
// extra cycle of latency on every status pin
module osc_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // pin side and clean side
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // hold while the two stages disagree
      q    <= (s2_r & s3_r) | (q & (s2_r | s3_r));
    end
  end

endmodule // osc_sync

// File: design/osc_map.vh
`ifndef OSC_MAP_VH
`define OSC_MAP_VH
// register indices as printed; byte address is four times the index
`define OSC_IDX_REQ      12'h28d
`define OSC_IDX_CUR      12'h28e
`define OSC_IDX_SWCTL    12'h28f
`define OSC_IDX_STAT     12'h290
`define OSC_IDX_FORCE    12'h291
`define OSC_IDX_TRIM     12'h292
`define OSC_IDX_FRQ      12'h293
`define OSC_IDX_AUTO     12'h294
// request / current fields
`define OSC_SRC_HI       6
`define OSC_SRC_LO       4
`define OSC_DIV_HI       3
`define OSC_DIV_LO       0
// switch control fields
`define OSC_HOLD_BIT     7
`define OSC_SPWR_BIT     6
`define OSC_DONE_BIT     4
`define OSC_NRDY_BIT     3
// force enable fields
`define OSC_FEN_MASK     8'hfd
`define OSC_PLLSEL_BIT   0
// auto trim enable position in own register
`define OSC_AUTO_BIT     7
// frequency select
`define OSC_FRQ_MAX      3'h5
// reset values
`define OSC_RST_ZERO     8'h00
`define OSC_RST_FRQ      3'h0
// reserved source codes: 3'h3 and 3'h7 (one-hot-ish table is outside)
`define OSC_SRC_RSVD_A   3'h3
`define OSC_SRC_RSVD_B   3'h7
// axi responses
`define OSC_RESP_OKAY    2'h0
`define OSC_RESP_SLVERR  2'h2
`endif
